// file: src/sgp_pkg.sv
// package: register map, field layout, reset values and timing of the global control bank
package sgp_pkg;

   // -------------------------------------------------------------------------
   // register indices (byte address is four times the index)
   // -------------------------------------------------------------------------
   localparam logic [5:0] IDX_CLOCK_OUTPUT_CONTROL = 6'h0B;
   localparam logic [5:0] IDX_MISC_PORT_CONTROL    = 6'h0C;
   localparam logic [5:0] IDX_FACTORY_TEST_REG     = 6'h0D;
   localparam logic [5:0] IDX_POWER_MODE_CONTROL   = 6'h0E;
   localparam logic [5:0] IDX_SLEEP_DELAY_CONTROL  = 6'h0F;

   // -------------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------------
   localparam int POS_REF_CLOCK_EN    = 1;
   localparam int POS_SPI_READ_EDGE   = 0;
   localparam int POS_TAIL_TAG_EN     = 1;
   localparam int POS_PASS_PAUSE      = 0;
   localparam int POS_PLL_PD_EN       = 5;
   localparam int POS_PWR_MODE_LO     = 3;
   localparam int POS_PWR_MODE_HI     = 4;

   // -------------------------------------------------------------------------
   // reset and fixed values
   // -------------------------------------------------------------------------
   localparam logic [7:0] MISC_FIXED_BITS     = 8'h44;
   localparam logic [7:0] FACTORY_TEST_VALUE  = 8'h00;
   localparam logic [7:0] SLEEP_DELAY_RESET   = 8'h50;
   localparam logic       SPI_READ_EDGE_RESET = 1'h0;
   localparam logic       TAIL_TAG_RESET      = 1'h0;
   localparam logic       PASS_PAUSE_RESET    = 1'h0;
   localparam logic       PLL_PD_RESET        = 1'h0;
   localparam logic       REF_CLOCK_EN_RESET  = 1'h0;
   localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

   // -------------------------------------------------------------------------
   // power management modes
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      normal_power_state    = 2'h0,
      energy_detect_state   = 2'h1,
      soft_power_down_state = 2'h2,
      reserved_power_state  = 2'h3
   } sgp_pwr_mode_t;

   // -------------------------------------------------------------------------
   // bus answers
   // -------------------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // -------------------------------------------------------------------------
   // timing
   // -------------------------------------------------------------------------
   localparam int CLK_MHZ            = 100;
   localparam int REF_CLOCK_MHZ      = 25;
   localparam int REF_HALF_CYCLES    = CLK_MHZ / (2 * REF_CLOCK_MHZ);
   localparam int SLEEP_UNIT_MS      = 20;
   localparam int SLEEP_UNIT_CYCLES  = SLEEP_UNIT_MS * 1000 * CLK_MHZ;

endpackage : sgp_pkg

// file: src/sgp_sleep_if.sv
// interface: sleep-timer hand-off between the register bank and the no-energy timer
`timescale 1ns/1ps
interface sgp_sleep_if;
   logic       enable;
   logic       noEnergy;
   logic [7:0] sleepDelay;
   logic       asleep;

   modport ctrl  (output enable, output noEnergy, output sleepDelay, input asleep);
   modport timer (input enable, input noEnergy, input sleepDelay, output asleep);
endinterface : sgp_sleep_if

// file: src/sgp_sleep_timer.sv
// module: counts uninterrupted no-energy time in sleep units and flags entry to low power
`timescale 1ns/1ps
module sgp_sleep_timer #(
   parameter int UNIT_CYCLES = sgp_pkg::SLEEP_UNIT_CYCLES
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // link to register bank
   sgp_sleep_if.timer sleepLink
);
   import sgp_pkg::*;

   // -------------------------------------------------------------------------
   // counters
   // -------------------------------------------------------------------------
   logic [31:0] tickCount;
   logic [7:0]  unitCount;
   logic        asleep;

   wire counting = sleepLink.enable && sleepLink.noEnergy;
   wire unitDone = (tickCount == 32'(UNIT_CYCLES - 1));
   wire reached  = (unitCount >= sleepLink.sleepDelay);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tickCount <= 32'h0;
         unitCount <= 8'h0;
         asleep    <= 1'b0;
      end else if (!counting) begin
         tickCount <= 32'h0;
         unitCount <= 8'h0;
         asleep    <= 1'b0;
      end else begin
         tickCount <= unitDone ? 32'h0 : tickCount + 32'h1;
         if (unitDone && !reached) begin
            unitCount <= unitCount + 8'h1;
         end
         asleep <= reached;
      end
   end

   assign sleepLink.asleep = asleep;

endmodule : sgp_sleep_timer

// file: src/sgp_regs.sv
// module: global control and power-management register bank on an AXI4-Lite slave
//
// Function
// - enable bit set drives continuous 25 MHz clock on output pin, else none.
// - enable bit resets to strap pin level latched at reset; pulled up enables.
// - read edge bit: 1 rising edge for fast clocks, 0 falling edge default.
// - tail-tag bit 1 inserts one byte before FCS on port 4 only.
// - pass-pause bit 1 forwards 802.3x frames; 0 default filters them.
// - PLL power-down bit 1 stops PLL only in energy-detect mode.
// - mode field 00 normal, 01 energy detect, 10 soft power-down, 11 reserved.
// - mode field is writable and cleared to 00 by a software read.
// - sleep-delay field resets to 0x50, eighty units, 1.6 seconds.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sgp_regs #(
   parameter int ADDR_W      = 8,
   parameter int UNIT_CYCLES = sgp_pkg::SLEEP_UNIT_CYCLES
) (
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   // axi4-lite write address
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic [2:0]           s_axi_awprot,
   // axi4-lite write data
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   // axi4-lite write response
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   output logic [1:0]                s_axi_bresp,
   // axi4-lite read address
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   input  wire logic [ADDR_W-1:0]    s_axi_araddr,
   input  wire logic [2:0]           s_axi_arprot,
   // axi4-lite read data
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   // pins and neighbouring logic
   input  wire logic                 clockOutStrapPin,
   input  wire logic                 noEnergyDetected,
   output logic                      refClockOut,
   // control outputs
   output logic                      spiReadRisingEdge,
   output logic                      tailTagEnable,
   output logic                      passPauseFrames,
   output logic                      pllPowerDown,
   output sgp_pkg::sgp_pwr_mode_t    powerMode,
   output logic                      energyDetectPowerDown,
   output logic                      softPowerDown
);
   import sgp_pkg::*;

   // -------------------------------------------------------------------------
   // storage
   // -------------------------------------------------------------------------
   logic            refClockEn;
   logic            spiReadEdge;
   logic            tailTagEn;
   logic            passPause;
   logic            pllPdEn;
   sgp_pwr_mode_t   pwrMode;
   logic [7:0]      sleepDelay;

   // -------------------------------------------------------------------------
   // input synchronisers
   // -------------------------------------------------------------------------
   logic strapMeta;
   logic strapSync;
   logic noEnergyMeta;
   logic noEnergySync;
   logic [1:0] strapCount;
   logic       strapDone;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         strapMeta    <= 1'b0;
         strapSync    <= 1'b0;
         noEnergyMeta <= 1'b0;
         noEnergySync <= 1'b0;
      end else begin
         strapMeta    <= clockOutStrapPin;
         strapSync    <= strapMeta;
         noEnergyMeta <= noEnergyDetected;
         noEnergySync <= noEnergyMeta;
      end
   end

   // strap is caught once, after the synchroniser has filled
   wire strapLoad = !strapDone && (strapCount == STRAP_SETTLE_CYCLES);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         strapCount <= 2'h0;
         strapDone  <= 1'b0;
      end else if (!strapDone) begin
         strapCount <= strapCount + 2'h1;
         strapDone  <= strapLoad;
      end
   end

   // -------------------------------------------------------------------------
   // write channel
   // -------------------------------------------------------------------------
   logic              awHeld;
   logic              wHeld;
   logic [ADDR_W-1:0] awAddr;
   logic [7:0]        wByte;
   logic              wLane;
   logic              bValid;
   logic [1:0]        bResp;

   wire awTake  = s_axi_awvalid && s_axi_awready;
   wire wTake   = s_axi_wvalid && s_axi_wready;
   wire doWrite = awHeld && wHeld && !bValid;

   wire [5:0] wIdx     = awAddr[7:2];
   wire       wMapped  = (wIdx >= IDX_CLOCK_OUTPUT_CONTROL) && (wIdx <= IDX_SLEEP_DELAY_CONTROL);
   wire       wrEnable = doWrite && wMapped && wLane;
   wire       wrClock  = wrEnable && (wIdx == IDX_CLOCK_OUTPUT_CONTROL);
   wire       wrMisc   = wrEnable && (wIdx == IDX_MISC_PORT_CONTROL);
   wire       wrPower  = wrEnable && (wIdx == IDX_POWER_MODE_CONTROL);
   wire       wrSleep  = wrEnable && (wIdx == IDX_SLEEP_DELAY_CONTROL);

   assign s_axi_awready = !awHeld && !bValid;
   assign s_axi_wready  = !wHeld && !bValid;
   assign s_axi_bvalid  = bValid;
   assign s_axi_bresp   = bResp;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         awHeld <= 1'b0;
         awAddr <= '0;
      end else if (awTake) begin
         awHeld <= 1'b1;
         awAddr <= s_axi_awaddr;
      end else if (doWrite) begin
         awHeld <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wHeld <= 1'b0;
         wByte <= 8'h0;
         wLane <= 1'b0;
      end else if (wTake) begin
         wHeld <= 1'b1;
         wByte <= s_axi_wdata[7:0];
         wLane <= s_axi_wstrb[0];
      end else if (doWrite) begin
         wHeld <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bValid <= 1'b0;
         bResp  <= RESP_OKAY;
      end else if (doWrite) begin
         bValid <= 1'b1;
         bResp  <= wMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bValid <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // read channel
   // -------------------------------------------------------------------------
   logic        rValid;
   logic [31:0] rData;
   logic [1:0]  rResp;

   wire       arTake  = s_axi_arvalid && s_axi_arready;
   wire [5:0] rIdx    = s_axi_araddr[7:2];
   wire       rMapped = (rIdx >= IDX_CLOCK_OUTPUT_CONTROL) && (rIdx <= IDX_SLEEP_DELAY_CONTROL);
   wire       rdPower = arTake && (rIdx == IDX_POWER_MODE_CONTROL);

   // fixed bits come from constants only, so writes cannot touch them
   wire [7:0] clockReg = {6'h00, refClockEn, spiReadEdge};
   wire [7:0] miscReg  = MISC_FIXED_BITS | {6'h00, tailTagEn, passPause};
   wire [7:0] powerReg = {2'h0, pllPdEn, pwrMode, 3'h0};
   wire [7:0] readByte =
      (rIdx == IDX_CLOCK_OUTPUT_CONTROL) ? clockReg :
      (rIdx == IDX_MISC_PORT_CONTROL)    ? miscReg :
      (rIdx == IDX_FACTORY_TEST_REG)     ? FACTORY_TEST_VALUE :
      (rIdx == IDX_POWER_MODE_CONTROL)   ? powerReg :
      (rIdx == IDX_SLEEP_DELAY_CONTROL)  ? sleepDelay : 8'h00;

   assign s_axi_arready = !rValid;
   assign s_axi_rvalid  = rValid;
   assign s_axi_rdata   = rData;
   assign s_axi_rresp   = rResp;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rValid <= 1'b0;
         rData  <= 32'h0;
         rResp  <= RESP_OKAY;
      end else if (arTake) begin
         rValid <= 1'b1;
         rData  <= {24'h000000, readByte};
         rResp  <= rMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rValid <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // control registers
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         refClockEn  <= REF_CLOCK_EN_RESET;
         spiReadEdge <= SPI_READ_EDGE_RESET;
      end else begin
         if (strapLoad) begin
            refClockEn <= strapSync;
         end else if (wrClock) begin
            refClockEn <= wByte[POS_REF_CLOCK_EN];
         end
         if (wrClock) begin
            spiReadEdge <= wByte[POS_SPI_READ_EDGE];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tailTagEn <= TAIL_TAG_RESET;
         passPause <= PASS_PAUSE_RESET;
      end else if (wrMisc) begin
         tailTagEn <= wByte[POS_TAIL_TAG_EN];
         passPause <= wByte[POS_PASS_PAUSE];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pllPdEn <= PLL_PD_RESET;
         pwrMode <= normal_power_state;
      end else begin
         if (wrPower) begin
            pllPdEn <= wByte[POS_PLL_PD_EN];
         end
         // a write in the same cycle as a clearing read wins
         if (wrPower) begin
            pwrMode <= sgp_pwr_mode_t'(wByte[POS_PWR_MODE_HI:POS_PWR_MODE_LO]);
         end else if (rdPower) begin
            pwrMode <= normal_power_state;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sleepDelay <= SLEEP_DELAY_RESET;
      end else if (wrSleep) begin
         sleepDelay <= wByte;
      end
   end

   // -------------------------------------------------------------------------
   // reference clock divider
   // -------------------------------------------------------------------------
   logic [1:0] refCount;
   logic       refPhase;

   wire refHalfDone = (refCount == 2'(REF_HALF_CYCLES - 1));

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         refCount <= 2'h0;
         refPhase <= 1'b0;
      end else if (!refClockEn) begin
         refCount <= 2'h0;
         refPhase <= 1'b0;
      end else begin
         refCount <= refHalfDone ? 2'h0 : refCount + 2'h1;
         if (refHalfDone) begin
            refPhase <= !refPhase;
         end
      end
   end

   assign refClockOut = refPhase;

   // -------------------------------------------------------------------------
   // power management
   // -------------------------------------------------------------------------
   sgp_sleep_if sleepLink ();

   assign sleepLink.enable     = (pwrMode == energy_detect_state);
   assign sleepLink.noEnergy   = noEnergySync;
   assign sleepLink.sleepDelay = sleepDelay;

   sgp_sleep_timer #(
      .UNIT_CYCLES (UNIT_CYCLES)
   ) u_sleep_timer (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .sleepLink (sleepLink.timer)
   );

   logic edpdState;
   logic pllDown;
   logic softDown;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         edpdState <= 1'b0;
         pllDown   <= 1'b0;
         softDown  <= 1'b0;
      end else begin
         edpdState <= sleepLink.asleep;
         pllDown   <= pllPdEn && (pwrMode == energy_detect_state);
         softDown  <= (pwrMode == soft_power_down_state);
      end
   end

   // -------------------------------------------------------------------------
   // control outputs
   // -------------------------------------------------------------------------
   assign spiReadRisingEdge     = spiReadEdge;
   assign tailTagEnable         = tailTagEn;
   assign passPauseFrames       = passPause;
   assign pllPowerDown          = pllDown;
   assign powerMode             = pwrMode;
   assign energyDetectPowerDown = edpdState;
   assign softPowerDown         = softDown;

   // protection bits are accepted and not used
   wire unusedProt = ^{s_axi_awprot, s_axi_arprot, awAddr[1:0]};

endmodule : sgp_regs

// file: dv/sgp_regs_sva.sv
// checker: port-level behaviour of the global control register bank
`timescale 1ns/1ps
module sgp_regs_sva #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic                   clk_sys,
   input wire logic                   rst_n,
   // bus
   input wire logic                   s_axi_arvalid,
   input wire logic                   s_axi_arready,
   input wire logic [ADDR_W-1:0]      s_axi_araddr,
   input wire logic                   s_axi_bvalid,
   input wire logic                   s_axi_rvalid,
   input wire logic [31:0]            s_axi_rdata,
   // control outputs
   input wire logic                   refClockOut,
   input wire logic                   spiReadRisingEdge,
   input wire logic                   tailTagEnable,
   input wire logic                   passPauseFrames,
   input wire logic                   pllPowerDown,
   input wire sgp_pkg::sgp_pwr_mode_t powerMode,
   input wire logic                   energyDetectPowerDown,
   input wire logic                   softPowerDown
);
   import sgp_pkg::*;
   // ----------
   // read index capture
   // ----------
   logic [5:0] rdIdx;
   wire        arTake = s_axi_arvalid && s_axi_arready;
   wire        rdDone = s_axi_rvalid;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) rdIdx <= 6'h00;
      else if (arTake) rdIdx <= s_axi_araddr[7:2];
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ----------
   // properties
   // ----------
   property p_clk_low;
      $fell(refClockOut) |=> !refClockOut;
   endproperty
   a_clk_low: assert property (p_clk_low) else $error("ref clock low phase short");
   property p_edge_sel;
      $changed(spiReadRisingEdge) |-> $rose(s_axi_bvalid);
   endproperty
   a_edge_sel: assert property (p_edge_sel) else $error("edge select moved");
   property p_port_bits;
      $changed({tailTagEnable, passPauseFrames}) |-> $rose(s_axi_bvalid);
   endproperty
   a_port_bits: assert property (p_port_bits) else $error("port bits moved");
   property p_pll;
      pllPowerDown |-> $past(powerMode) == energy_detect_state;
   endproperty
   a_pll: assert property (p_pll) else $error("pll down outside energy mode");
   property p_soft;
      softPowerDown == ($past(powerMode) == soft_power_down_state);
   endproperty
   a_soft: assert property (p_soft) else $error("soft power-down wrong");
   property p_rc;
      arTake && s_axi_araddr[7:2] == IDX_POWER_MODE_CONTROL
         |=> powerMode == normal_power_state || $rose(s_axi_bvalid);
   endproperty
   a_rc: assert property (p_rc) else $error("mode not cleared by read");
   property p_rc_data;
      $rose(rdDone) && rdIdx == IDX_POWER_MODE_CONTROL
         |-> {s_axi_rdata[7:6], s_axi_rdata[4:0]} == {2'h0, $past(powerMode), 3'h0};
   endproperty
   a_rc_data: assert property (p_rc_data) else $error("mode read data wrong");
   property p_misc;
      $rose(rdDone) && rdIdx == IDX_MISC_PORT_CONTROL |-> s_axi_rdata[7:2] == 6'h11;
   endproperty
   a_misc: assert property (p_misc) else $error("fixed bits wrong");
   property p_fact;
      $rose(rdDone) && rdIdx == IDX_FACTORY_TEST_REG |-> s_axi_rdata[7:0] == FACTORY_TEST_VALUE;
   endproperty
   a_fact: assert property (p_fact) else $error("test register wrong");
   property p_sleep;
      $rose(energyDetectPowerDown)
         |-> powerMode == energy_detect_state && $past(powerMode) == energy_detect_state;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep outside energy mode");
endmodule : sgp_regs_sva

bind sgp_regs sgp_regs_sva #(.ADDR_W(ADDR_W)) u_sva (.clk_sys, .rst_n, .s_axi_arvalid,
   .s_axi_arready, .s_axi_araddr, .s_axi_bvalid, .s_axi_rvalid, .s_axi_rdata, .refClockOut,
   .spiReadRisingEdge, .tailTagEnable, .passPauseFrames, .pllPowerDown, .powerMode,
   .energyDetectPowerDown, .softPowerDown);

// file: dv/tb_sgp_regs.sv
// testbench: global control and power-management register bank
`timescale 1ns/1ps
module tb_sgp_regs;
   import sgp_pkg::*;
   localparam int         UNIT   = 10;
   localparam logic [7:0] A_CLK  = {IDX_CLOCK_OUTPUT_CONTROL, 2'b00};
   localparam logic [7:0] A_MISC = {IDX_MISC_PORT_CONTROL, 2'b00};
   localparam logic [7:0] A_FACT = {IDX_FACTORY_TEST_REG, 2'b00};
   localparam logic [7:0] A_MODE = {IDX_POWER_MODE_CONTROL, 2'b00};
   localparam logic [7:0] A_SLP  = {IDX_SLEEP_DELAY_CONTROL, 2'b00};
   logic          clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic          s_axi_rready, clockOutStrapPin, noEnergyDetected, refClockOut;
   logic          spiReadRisingEdge, tailTagEnable, passPauseFrames, pllPowerDown;
   logic          energyDetectPowerDown, softPowerDown;
   logic [7:0]    s_axi_awaddr, s_axi_araddr;
   logic [31:0]   s_axi_wdata, s_axi_rdata;
   logic [1:0]    s_axi_bresp, s_axi_rresp, rsp;
   sgp_pwr_mode_t powerMode;
   int            errorCnt, cmpCount, cycles;

   sgp_regs #(.UNIT_CYCLES(UNIT)) dut (.clk_sys, .rst_n, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
      .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .clockOutStrapPin, .noEnergyDetected, .refClockOut,
      .spiReadRisingEdge, .tailTagEnable, .passPauseFrames, .pllPowerDown, .powerMode,
      .energyDetectPowerDown, .softPowerDown);

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         errorCnt++;
         end_of_test();
      end
   end
   // ----------
   // helpers
   // ----------
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      cmpCount++;
      if (got !== exp) begin
         errorCnt++;
         $display("mismatch at %0t: expected %0h got %0h", $time, exp, got);
      end
   endtask : chk
   task automatic do_reset(input logic strap);
      clockOutStrapPin <= strap;
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask : do_reset
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      do @(posedge clk_sys); while (!s_axi_bvalid);
      rsp = s_axi_bresp;
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk_sys); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk_sys); while (!s_axi_rvalid);
      rsp = s_axi_rresp;
      chk(exp, s_axi_rdata);
   endtask : rchk
   task automatic clk_shape(input logic [31:0] exp);
      int   hi;
      int   ed;
      logic pv;
      hi = 0;
      ed = 0;
      repeat (4) @(posedge clk_sys);
      pv = refClockOut;
      repeat (16) begin
         @(posedge clk_sys);
         if (refClockOut === 1'b1) hi++;
         if (refClockOut !== pv) ed++;
         pv = refClockOut;
      end
      chk(exp, {hi[15:0], ed[15:0]});
   endtask : clk_shape
   task automatic wait_sleep(output int n);
      n = 0;
      noEnergyDetected <= 1'b1;
      while (energyDetectPowerDown !== 1'b1 && n < 200) begin
         @(posedge clk_sys);
         n++;
      end
   endtask : wait_sleep
   // ----------
   // scenarios
   // ----------
   task automatic t_reset_values;
      rchk(A_CLK, 32'h02);
      rchk(A_MISC, 32'h44);
      rchk(A_FACT, 32'h00);
      rchk(A_MODE, 32'h00);
      rchk(A_SLP, 32'h50);
      do_reset(1'b0);
      rchk(A_CLK, 32'h00);
      clk_shape(32'h0);
      do_reset(1'b1);
   endtask : t_reset_values
   task automatic t_ref_clock;
      clk_shape(32'h0008_0008);
      wr(A_CLK, 8'h01);
      clk_shape(32'h0);
      chk(32'h1, 32'(spiReadRisingEdge));
      wr(A_CLK, 8'hFF);
      rchk(A_CLK, 32'h03);
      clk_shape(32'h0008_0008);
   endtask : t_ref_clock
   task automatic t_misc_bits;
      wr(A_MISC, 8'hFF);
      rchk(A_MISC, 32'h47);
      chk(32'h3, 32'({tailTagEnable, passPauseFrames}));
      wr(A_MISC, 8'h02);
      chk(32'h2, 32'({tailTagEnable, passPauseFrames}));
      wr(A_FACT, 8'hFF);
      rchk(A_FACT, 32'h00);
      wr(8'h40, 8'h12);
      chk(32'(RESP_SLVERR), 32'(rsp));
      rchk(8'h40, 32'h0);
      chk(32'(RESP_SLVERR), 32'(rsp));
   endtask : t_misc_bits
   task automatic t_power_modes;
      logic [7:0] v;
      for (int m = 0; m < 3; m++) begin
         v = 8'h20 | 8'(m << 3);
         wr(A_MODE, v | 8'hC7);
         @(posedge clk_sys);
         chk(32'(m), 32'(powerMode));
         chk(32'(m == 1), 32'(pllPowerDown));
         chk(32'(m == 2), 32'(softPowerDown));
         rchk(A_MODE, 32'(v));
         rchk(A_MODE, 32'h20);
         chk(32'h0, 32'(powerMode));
      end
   endtask : t_power_modes
   task automatic t_sleep;
      int n;
      wr(A_SLP, 8'h03);
      rchk(A_SLP, 32'h03);
      wr(A_MODE, 8'h08);
      @(posedge clk_sys);
      chk(32'h0, 32'(pllPowerDown));
      wait_sleep(n);
      chk(32'h1, 32'(n >= 3 * UNIT && n <= 3 * UNIT + 16));
      noEnergyDetected <= 1'b0;
      repeat (20) @(posedge clk_sys);
      chk(32'h0, 32'(energyDetectPowerDown));
      noEnergyDetected <= 1'b1;
      repeat (20) @(posedge clk_sys);
      noEnergyDetected <= 1'b0;
      repeat (4) @(posedge clk_sys);
      wait_sleep(n);
      chk(32'h1, 32'(n >= 3 * UNIT && n <= 3 * UNIT + 16));
      wr(A_MODE, 8'h00);
      noEnergyDetected <= 1'b0;
   endtask : t_sleep
   task automatic end_of_test;
      $display("errors %0d comparisons %0d", errorCnt, cmpCount);
      if (errorCnt == 0 && cmpCount > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   initial begin
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {clockOutStrapPin, noEnergyDetected, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {errorCnt, cmpCount, cycles} = '0;
      do_reset(1'b1);
      t_reset_values();
      t_ref_clock();
      t_misc_bits();
      t_power_modes();
      t_sleep();
      end_of_test();
   end
endmodule : tb_sgp_regs
